// file: bench/clear_pin_model.sv
// Behavioural driver of the master clear pin
`timescale 1ns/1ps
module clear_pin_model (
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Bench request
    input  wire logic       press,
    input  wire logic [7:0] press_len,
    // Pin
    output logic            master_clear_pin_n
);
    logic [7:0] left_q;

    // Pin idles high, as with its pull-up to supply
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            left_q <= 8'h00;
        end else if (press) begin
            left_q <= press_len;
        end else if (left_q != 8'h00) begin
            left_q <= left_q - 8'h01;
        end
    end
    assign master_clear_pin_n = (left_q == 8'h00);
endmodule : clear_pin_model

// file: bench/reset_cause_chk.sv
// Concurrent checks on the state loader ports
`timescale 1ns/1ps
module reset_cause_chk (
    input wire logic                              pclk,
    input wire logic                              presetn,
    input wire logic                              psel,
    input wire logic                              penable,
    input wire logic [7:0]                        paddr,
    input wire logic                              pready,
    input wire logic [31:0]                       prdata,
    input wire logic                              pslverr,
    input wire logic                              master_clear_pin_n,
    input wire logic                              core_hold,
    input wire logic [reset_cause_pkg::PC_W-1:0]  program_counter,
    input wire logic [1:0]                        power_control_reg,
    input wire reset_cause_pkg::init_class_t      sfr_init_class,
    input wire logic                              sfr_init_strobe
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence setup_s;
        psel && !penable;
    endsequence
    sequence access_s;
        psel && penable && !pready;
    endsequence

    apb_wait_a: assert property (setup_s ##1 access_s |=> pready) else $error("answer not one cycle late");
    ready_pulse_a: assert property (pready |=> !pready) else $error("ready held too long");
    unmapped_err_a: assert property (pready && paddr > 8'h18 |-> pslverr && prdata == 32'h0000_0000)
        else $error("unmapped access not refused");
    mapped_ok_a: assert property (pready && paddr <= 8'h18 && paddr[1:0] == 2'b00 |-> !pslverr)
        else $error("mapped access refused");
    strobe_pulse_a: assert property (sfr_init_strobe |=> !sfr_init_strobe) else $error("strobe too long");
    pin_latch_a: assert property (!core_hold && !master_clear_pin_n |=> core_hold) else $error("pin not taken");
    pin_hold_a: assert property (core_hold && !master_clear_pin_n |=> core_hold) else $error("core freed early");
    pin_zero_a: assert property (sfr_init_strobe && sfr_init_class == reset_cause_pkg::CLASS_PIN_WD
        |-> program_counter == 13'h0000) else $error("counter not zero");
    power_control_reg_keep_a: assert property (sfr_init_strobe && sfr_init_class != reset_cause_pkg::CLASS_POWER
        |-> $stable(power_control_reg)) else $error("power bits changed");
    release_a: assert property (sfr_init_strobe |-> !core_hold) else $error("core still held");
endmodule : reset_cause_chk

bind reset_cause_state_loader reset_cause_chk reset_cause_chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .paddr(paddr), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .master_clear_pin_n(master_clear_pin_n), .core_hold(core_hold), .program_counter(program_counter),
    .power_control_reg(power_control_reg), .sfr_init_class(sfr_init_class), .sfr_init_strobe(sfr_init_strobe));

// file: bench/testbench.sv
// Self-checking bench for the reset cause state loader
`timescale 1ns/1ps
module testbench;
    logic                         pclk = 1'b0;
    logic                         presetn = 1'b0;
    logic                         psel = 1'b0;
    logic                         penable = 1'b0;
    logic                         pwrite = 1'b0;
    logic [7:0]                   paddr = 8'h00;
    logic [31:0]                  pwdata = 32'h0000_0000;
    logic                         pready, pslverr, core_hold, sfr_init_strobe, master_clear_pin_n;
    logic [31:0]                  prdata, rdata;
    logic                         rerr;
    logic                         press = 1'b0;
    logic [7:0]                   press_len = 8'h00;
    reset_cause_pkg::events_t     events = '0;
    reset_cause_pkg::wake_flags_t wake_flags = '0;
    logic [12:0]                  program_counter;
    logic [7:0]                   core_status, core_irq_control_reg, periph_irq_flags_a, periph_irq_flags_b;
    logic [1:0]                   power_control_reg;
    reset_cause_pkg::init_class_t sfr_init_class;
    int                           failures = 0;
    int                           compares = 0;
    int                           cycles = 0;

    reset_cause_state_loader reset_cause_state_loader_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .master_clear_pin_n(master_clear_pin_n), .events(events), .wake_flags(wake_flags),
        .core_hold(core_hold), .program_counter(program_counter), .core_status(core_status),
        .power_control_reg(power_control_reg), .core_irq_control_reg(core_irq_control_reg),
        .periph_irq_flags_a(periph_irq_flags_a), .periph_irq_flags_b(periph_irq_flags_b),
        .sfr_init_class(sfr_init_class), .sfr_init_strobe(sfr_init_strobe));
    clear_pin_model clear_pin_model_i (.pclk(pclk), .presetn(presetn), .press(press), .press_len(press_len),
        .master_clear_pin_n(master_clear_pin_n));

    always #12.5 pclk = ~pclk;

    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            tally_and_finish();
        end
    end

    task tally_and_finish();
        $display("Compares %0d, mismatches %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : tally_and_finish

    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // One transfer; request held until ready is seen at an edge
    task apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wait_strobe();
        do begin
            @(posedge pclk);
            #1;
        end while (sfr_init_strobe !== 1'b1);
    endtask : wait_strobe

    // Fires one event and checks the status and power loads against the old register values
    task ev_run(input logic [3:0] ev, input logic [7:0] len, input logic [23:0] wf, input logic [2:0] cause,
                input logic [1:0] cls, input logic [12:0] pc_exp, input logic [7:0] sm, input logic [7:0] sv,
                input logic [1:0] pm, input logic [1:0] pv);
        logic [7:0] st;
        logic [1:0] po;
        apb(1'b0, reset_cause_pkg::OFF_STATUS, 32'h0000_0000);
        st = rdata[7:0];
        apb(1'b0, reset_cause_pkg::OFF_POWER, 32'h0000_0000);
        po = rdata[1:0];
        @(posedge pclk);
        events <= ev;
        wake_flags <= wf;
        press <= (len != 8'h00);
        press_len <= len;
        @(posedge pclk);
        press <= 1'b0;
        @(posedge pclk);
        events <= '0;
        wait_strobe();
        chk("class", {30'h0, cls}, {30'h0, sfr_init_class});
        chk("counter", {19'h0, pc_exp}, {19'h0, program_counter});
        chk("status", {24'h0, (st & ~sm) | sv}, {24'h0, core_status});
        chk("power", {30'h0, (po & ~pm) | pv}, {30'h0, power_control_reg});
        chk("wake flags", {8'h0, wf}, {8'h0, {core_irq_control_reg, periph_irq_flags_a, periph_irq_flags_b} & wf});
        @(posedge pclk);
        wake_flags <= '0;
        apb(1'b0, reset_cause_pkg::OFF_CAUSE, 32'h0000_0000);
        chk("cause", {29'h0, cause}, rdata);
    endtask : ev_run

    // ****************************************
    // Scenarios
    // ****************************************
    task s_power_on();
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        wait_strobe();
        chk("por class", 32'h1, {30'h0, sfr_init_class});
        chk("por status", 32'h18, {24'h0, core_status});
        chk("por power", 32'h1, {30'h0, power_control_reg});
    endtask : s_power_on

    task s_regs();
        apb(1'b1, reset_cause_pkg::OFF_POWER, 32'hffff_ffff);
        apb(1'b0, reset_cause_pkg::OFF_POWER, 32'h0000_0000);
        chk("power readback", 32'h3, rdata);
        apb(1'b0, 8'h40, 32'h0000_0000);
        chk("unmapped", 32'h1, {31'h0, rerr});
        chk("unmapped data", 32'h0, rdata);
    endtask : s_regs

    task s_wakes();
        apb(1'b1, reset_cause_pkg::OFF_PC, 32'h0000_0010);
        ev_run(4'b0011, 8'h00, 24'h02_01_08, 3'd6, 2'd3, 13'h0011, 8'h18, 8'h10, 2'h0, 2'h0);
        apb(1'b1, reset_cause_pkg::OFF_CORE_IRQ, 32'h0000_0080);
        ev_run(4'b0011, 8'h00, 24'h02_01_08, 3'd6, 2'd3, 13'h0004, 8'h18, 8'h10, 2'h0, 2'h0);
        apb(1'b1, reset_cause_pkg::OFF_PC, 32'h0000_1fff);
        ev_run(4'b0101, 8'h00, 24'h00_40_00, 3'd5, 2'd3, 13'h0000, 8'h18, 8'h00, 2'h0, 2'h0);
    endtask : s_wakes

    task s_resets();
        apb(1'b1, reset_cause_pkg::OFF_PC, 32'h0000_0123);
        apb(1'b1, reset_cause_pkg::OFF_CORE_IRQ, 32'h0000_0081);
        ev_run(4'b0000, 8'h05, 24'h0, 3'd2, 2'd2, 13'h0000, 8'he0, 8'h00, 2'h0, 2'h0);
        chk("irq kept bit", 32'h1, {24'h0, core_irq_control_reg});
        ev_run(4'b0001, 8'h04, 24'h0, 3'd3, 2'd2, 13'h0000, 8'hf8, 8'h10, 2'h0, 2'h0);
        ev_run(4'b0100, 8'h00, 24'h0, 3'd4, 2'd2, 13'h0000, 8'hf8, 8'h08, 2'h0, 2'h0);
        ev_run(4'b1000, 8'h00, 24'h0, 3'd1, 2'd1, 13'h0000, 8'hf8, 8'h18, 2'h1, 2'h0);
    endtask : s_resets

    initial begin
        s_power_on();
        s_regs();
        s_wakes();
        s_resets();
        tally_and_finish();
    end
endmodule : testbench

// file: logic/cause_encoder.sv
// Priority encoder from reset and wake-up detectors to one cause
`timescale 1ns/1ps
module cause_encoder (
    // Detectors
    input  wire reset_cause_pkg::events_t ev,
    input  wire logic                     master_clear_pin_n,
    // Result
    output reset_cause_pkg::cause_t       cause
);
    // ************************************************************
    // Brown-out outranks the pin, the pin outranks the watchdog
    // ************************************************************
    always_comb begin
        if (ev.brownout) begin
            cause = reset_cause_pkg::CAUSE_BROWN;
        end else if (!master_clear_pin_n) begin
            cause = ev.sleeping ? reset_cause_pkg::CAUSE_PIN_SLEEP
                                : reset_cause_pkg::CAUSE_PIN_RUN;
        end else if (ev.watchdog_timeout) begin
            // Timeout in sleep only resumes execution
            cause = ev.sleeping ? reset_cause_pkg::CAUSE_WD_WAKE
                                : reset_cause_pkg::CAUSE_WD_RESET;
        end else if (ev.irq_wake && ev.sleeping) begin
            cause = reset_cause_pkg::CAUSE_IRQ_WAKE;
        end else begin
            cause = reset_cause_pkg::CAUSE_NONE;
        end
    end
endmodule : cause_encoder

// file: logic/reset_cause_pkg.sv
// Shared constants and types for the reset cause state loader
package reset_cause_pkg;

    // ************************************************************
    // Widths and register offsets
    // ************************************************************
    localparam int           PC_W        = 13;
    localparam logic [7:0]   OFF_PC      = 8'h00;
    localparam logic [7:0]   OFF_STATUS  = 8'h04;
    localparam logic [7:0]   OFF_POWER   = 8'h08;
    localparam logic [7:0]   OFF_CORE_IRQ = 8'h0c;
    localparam logic [7:0]   OFF_PIR_A   = 8'h10;
    localparam logic [7:0]   OFF_PIR_B   = 8'h14;
    localparam logic [7:0]   OFF_CAUSE   = 8'h18;

    // ************************************************************
    // Reset values and field positions
    // ************************************************************
    localparam logic [12:0]  PC_RESET    = 13'h0000;
    localparam logic [12:0]  PC_VECTOR   = 13'h0004;
    localparam logic [7:0]   STATUS_POR  = 8'h18;
    localparam logic [1:0]   POWER_POR   = 2'h1;
    localparam int           TOUT_BIT    = 4;
    localparam int           PDN_BIT     = 3;
    localparam int           IRQ_EN_BIT  = 7;
    localparam int           POR_BIT     = 1;
    localparam int           BRN_BIT     = 0;
    localparam logic [7:0]   IRQ_KEEP_PIN = 8'h01;
    localparam logic [7:0]   PIR_A_IMPL  = 8'h7f;
    localparam logic [7:0]   PIR_B_IMPL  = 8'h0b;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [2:0] {
        CAUSE_POR        = 3'b000,
        CAUSE_BROWN      = 3'b001,
        CAUSE_PIN_RUN    = 3'b010,
        CAUSE_PIN_SLEEP  = 3'b011,
        CAUSE_WD_RESET   = 3'b100,
        CAUSE_WD_WAKE    = 3'b101,
        CAUSE_IRQ_WAKE   = 3'b110,
        CAUSE_NONE       = 3'b111
    } cause_t;

    typedef enum logic [1:0] {
        CLASS_NONE     = 2'b00,
        CLASS_POWER    = 2'b01,
        CLASS_PIN_WD   = 2'b10,
        CLASS_WAKE     = 2'b11
    } init_class_t;

    typedef enum logic [1:0] {
        PC_ZERO = 2'b00,
        PC_NEXT = 2'b01,
        PC_IRQ  = 2'b10
    } pc_sel_t;

    typedef enum logic [1:0] {
        ST_RUN   = 2'b00,
        ST_HOLD  = 2'b01,
        ST_APPLY = 2'b10
    } seq_state_t;

    typedef struct packed {
        logic brownout;
        logic watchdog_timeout;
        logic irq_wake;
        logic sleeping;
    } events_t;

    typedef struct packed {
        logic [7:0] core_irq;
        logic [7:0] pir_a;
        logic [7:0] pir_b;
    } wake_flags_t;

    typedef struct packed {
        pc_sel_t     pc_sel;
        logic [7:0]  st_mask;
        logic [7:0]  st_val;
        logic [1:0]  pwr_mask;
        logic [1:0]  pwr_val;
        init_class_t init_class;
    } load_plan_t;

endpackage : reset_cause_pkg

// file: logic/reset_cause_state_loader.sv
// Reset and wake-up state loader with an APB register port
// Behaviour
// - Pin reset while running: counter zero, upper three status bits cleared, rest kept
// - Pin reset in sleep: counter zero, timeout set, powerdown cleared, power bits kept
// - Interrupt wake: next address, timeout set, powerdown cleared, other status kept
// - Interrupt wake with global enable set loads the interrupt vector instead
// - A wake-up leaves its source flag set in the interrupt flag registers
// - Each cause has defined loads; power-on gives status 0001 1000, power bits 01
// - Register init uses three classes: power/brown-out, pin/watchdog, wake-up
// - Timeout and powerdown bits follow the exact cause of pin-in-sleep, watchdog or wake events; pin reset while running keeps them
// - Unimplemented bit positions read as zero
// - Power-on flag cleared only by power-on reset; software sets it later
// - Brown-out flag is bit zero, cleared by brown-out, set by software
// - Watchdog timeout in sleep is a wake-up: next address, timeout and powerdown cleared, source flag set, other registers keep their contents
`timescale 1ns/1ps
module reset_cause_state_loader (
    // Clock and reset
    input  wire logic                         pclk,
    input  wire logic                         presetn,
    // APB slave
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [7:0]                   paddr,
    input  wire logic [31:0]                  pwdata,
    output logic                              pready,
    output logic [31:0]                       prdata,
    output logic                              pslverr,
    // Pin and detectors
    input  wire logic                         master_clear_pin_n,
    input  wire reset_cause_pkg::events_t     events,
    input  wire reset_cause_pkg::wake_flags_t wake_flags,
    // Core side
    output logic                              core_hold,
    output logic [reset_cause_pkg::PC_W-1:0]  program_counter,
    output logic [7:0]                        core_status,
    output logic [1:0]                        power_control_reg,
    output logic [7:0]                        core_irq_control_reg,
    output logic [7:0]                        periph_irq_flags_a,
    output logic [7:0]                        periph_irq_flags_b,
    output reset_cause_pkg::init_class_t      sfr_init_class,
    output logic                              sfr_init_strobe
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        reset_cause_pkg::seq_state_t  seq;
        reset_cause_pkg::cause_t      cause;
        logic [reset_cause_pkg::PC_W-1:0] pc;
        logic [7:0]                   status;
        logic [1:0]                   pwr;
        logic [7:0]                   core_irq;
        logic [7:0]                   pir_a;
        logic [7:0]                   pir_b;
        logic                         hold;
        reset_cause_pkg::init_class_t init_class;
        logic                         init_strobe;
        logic                         ready;
        logic                         slverr;
        logic [31:0]                  rdata;
    } state_t;

    localparam state_t STATE_RESET = '{
        seq:         reset_cause_pkg::ST_APPLY,
        cause:       reset_cause_pkg::CAUSE_POR,
        pc:          reset_cause_pkg::PC_RESET,
        status:      reset_cause_pkg::STATUS_POR,
        pwr:         reset_cause_pkg::POWER_POR,
        core_irq:    8'h00,
        pir_a:       8'h00,
        pir_b:       8'h00,
        hold:        1'b1,
        init_class:  reset_cause_pkg::CLASS_NONE,
        init_strobe: 1'b0,
        ready:       1'b0,
        slverr:      1'b0,
        rdata:       32'h0000_0000
    };

    state_t                       s_q;
    state_t                       s_d;
    reset_cause_pkg::cause_t      live_cause;
    reset_cause_pkg::load_plan_t  plan;

    // ************************************************************
    // Cause detection and load table
    // ************************************************************
    cause_encoder u_encoder (
        .ev                 (events),
        .master_clear_pin_n (master_clear_pin_n),
        .cause              (live_cause)
    );

    reset_value_table u_table (
        .cause (s_q.cause),
        .plan  (plan)
    );

    // ************************************************************
    // Sequencer, loads and register port
    // ************************************************************
    always_comb begin
        logic        acc;
        logic        wr;
        logic        mapped;
        logic [31:0] rd;
        logic        irq_en;
        acc    = 1'b0;
        wr     = 1'b0;
        mapped = 1'b0;
        rd     = 32'h0000_0000;
        irq_en = 1'b0;
        s_d    = s_q;
        s_d.init_strobe = 1'b0;

        // Register writes land first so a same-cycle load overrides them
        acc = psel && penable && !s_q.ready;
        wr  = psel && penable && s_q.ready && pwrite && !s_q.slverr;
        if (wr) begin
            unique case (paddr)
                reset_cause_pkg::OFF_PC: begin
                    s_d.pc = pwdata[reset_cause_pkg::PC_W-1:0];
                end
                reset_cause_pkg::OFF_STATUS: begin
                    s_d.status = pwdata[7:0];
                end
                reset_cause_pkg::OFF_POWER: begin
                    // Software re-arms both flags after reading them
                    s_d.pwr = pwdata[1:0];
                end
                reset_cause_pkg::OFF_CORE_IRQ: begin
                    s_d.core_irq = pwdata[7:0];
                end
                reset_cause_pkg::OFF_PIR_A: begin
                    s_d.pir_a = pwdata[7:0] & reset_cause_pkg::PIR_A_IMPL;
                end
                reset_cause_pkg::OFF_PIR_B: begin
                    s_d.pir_b = pwdata[7:0] & reset_cause_pkg::PIR_B_IMPL;
                end
                default: begin
                end
            endcase
        end

        unique case (s_q.seq)
            reset_cause_pkg::ST_RUN: begin
                if (live_cause != reset_cause_pkg::CAUSE_NONE) begin
                    s_d.cause = live_cause;
                    s_d.hold  = 1'b1;
                    s_d.seq   = reset_cause_pkg::ST_HOLD;
                end
            end
            reset_cause_pkg::ST_HOLD: begin
                // Core stays held while the pin or brown-out persists
                if (master_clear_pin_n && !events.brownout) begin
                    s_d.seq = reset_cause_pkg::ST_APPLY;
                end else if (live_cause == reset_cause_pkg::CAUSE_BROWN) begin
                    s_d.cause = live_cause;
                end
            end
            reset_cause_pkg::ST_APPLY: begin
                irq_en = s_q.core_irq[reset_cause_pkg::IRQ_EN_BIT];
                s_d.status = (s_d.status & ~plan.st_mask)
                           | (plan.st_val & plan.st_mask);
                s_d.pwr    = (s_d.pwr & ~plan.pwr_mask)
                           | (plan.pwr_val & plan.pwr_mask);
                unique case (plan.pc_sel)
                    reset_cause_pkg::PC_ZERO: begin
                        s_d.pc = reset_cause_pkg::PC_RESET;
                    end
                    reset_cause_pkg::PC_NEXT: begin
                        s_d.pc = s_q.pc + 13'h0001;
                    end
                    reset_cause_pkg::PC_IRQ: begin
                        s_d.pc = irq_en ? reset_cause_pkg::PC_VECTOR
                                     : s_q.pc + 13'h0001;
                    end
                    default: begin
                        s_d.pc = reset_cause_pkg::PC_RESET;
                    end
                endcase
                unique case (plan.init_class)
                    reset_cause_pkg::CLASS_POWER: begin
                        s_d.core_irq = 8'h00;
                        s_d.pir_a    = 8'h00;
                        s_d.pir_b    = 8'h00;
                    end
                    reset_cause_pkg::CLASS_PIN_WD: begin
                        s_d.core_irq = s_d.core_irq & reset_cause_pkg::IRQ_KEEP_PIN;
                        s_d.pir_a    = 8'h00;
                        s_d.pir_b    = 8'h00;
                    end
                    reset_cause_pkg::CLASS_WAKE: begin
                        // Source flags set here win over a same-cycle clear
                        s_d.core_irq = s_d.core_irq | wake_flags.core_irq;
                        s_d.pir_a    = s_d.pir_a | (wake_flags.pir_a & reset_cause_pkg::PIR_A_IMPL);
                        s_d.pir_b    = s_d.pir_b | (wake_flags.pir_b & reset_cause_pkg::PIR_B_IMPL);
                    end
                    default: begin
                    end
                endcase
                s_d.init_class  = plan.init_class;
                s_d.init_strobe = 1'b1;
                s_d.hold        = 1'b0;
                s_d.seq         = reset_cause_pkg::ST_RUN;
            end
            default: begin
                s_d.seq = reset_cause_pkg::ST_RUN;
            end
        endcase

        // One wait state: data and pready come from flops
        mapped = 1'b1;
        unique case (paddr)
            reset_cause_pkg::OFF_PC:       rd = {19'h0_0000, s_q.pc};
            reset_cause_pkg::OFF_STATUS:   rd = {24'h00_0000, s_q.status};
            reset_cause_pkg::OFF_POWER:    rd = {30'h0000_0000, s_q.pwr};
            reset_cause_pkg::OFF_CORE_IRQ: rd = {24'h00_0000, s_q.core_irq};
            reset_cause_pkg::OFF_PIR_A:    rd = {24'h00_0000, s_q.pir_a};
            reset_cause_pkg::OFF_PIR_B:    rd = {24'h00_0000, s_q.pir_b};
            reset_cause_pkg::OFF_CAUSE:    rd = {29'h0000_0000, s_q.cause};
            default: begin
                mapped = 1'b0;
                rd     = 32'h0000_0000;
            end
        endcase
        s_d.ready  = acc;
        s_d.slverr = acc && !mapped;
        if (acc) begin
            s_d.rdata = pwrite ? 32'h0000_0000 : rd;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= STATE_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign pready               = s_q.ready;
    assign prdata               = s_q.rdata;
    assign pslverr              = s_q.slverr;
    assign core_hold            = s_q.hold;
    assign program_counter      = s_q.pc;
    assign core_status          = s_q.status;
    assign power_control_reg    = s_q.pwr;
    assign core_irq_control_reg = s_q.core_irq;
    assign periph_irq_flags_a   = s_q.pir_a;
    assign periph_irq_flags_b   = s_q.pir_b;
    assign sfr_init_class       = s_q.init_class;
    assign sfr_init_strobe      = s_q.init_strobe;

endmodule : reset_cause_state_loader

// file: logic/reset_value_table.sv
// Table of program counter, status and power-control loads per cause
`timescale 1ns/1ps
module reset_value_table (
    // Selected cause
    input  wire reset_cause_pkg::cause_t cause,
    // Load plan
    output reset_cause_pkg::load_plan_t  plan
);
    // ************************************************************
    // Mask marks bits the event defines, the rest stay unchanged
    // ************************************************************
    always_comb begin
        plan = '{reset_cause_pkg::PC_ZERO, 8'h00, 8'h00, 2'h0, 2'h0,
                 reset_cause_pkg::CLASS_NONE};
        unique case (cause)
            reset_cause_pkg::CAUSE_POR: begin
                plan = '{reset_cause_pkg::PC_ZERO, 8'hff, 8'h18, 2'h3, 2'h1,
                         reset_cause_pkg::CLASS_POWER};
            end
            reset_cause_pkg::CAUSE_BROWN: begin
                plan = '{reset_cause_pkg::PC_ZERO, 8'hf8, 8'h18, 2'h1, 2'h0,
                         reset_cause_pkg::CLASS_POWER};
            end
            reset_cause_pkg::CAUSE_PIN_RUN: begin
                plan = '{reset_cause_pkg::PC_ZERO, 8'he0, 8'h00, 2'h0, 2'h0,
                         reset_cause_pkg::CLASS_PIN_WD};
            end
            reset_cause_pkg::CAUSE_PIN_SLEEP: begin
                plan = '{reset_cause_pkg::PC_ZERO, 8'hf8, 8'h10, 2'h0, 2'h0,
                         reset_cause_pkg::CLASS_PIN_WD};
            end
            reset_cause_pkg::CAUSE_WD_RESET: begin
                plan = '{reset_cause_pkg::PC_ZERO, 8'hf8, 8'h08, 2'h0, 2'h0,
                         reset_cause_pkg::CLASS_PIN_WD};
            end
            reset_cause_pkg::CAUSE_WD_WAKE: begin
                plan = '{reset_cause_pkg::PC_NEXT, 8'h18, 8'h00, 2'h0, 2'h0,
                         reset_cause_pkg::CLASS_WAKE};
            end
            reset_cause_pkg::CAUSE_IRQ_WAKE: begin
                plan = '{reset_cause_pkg::PC_IRQ, 8'h18, 8'h10, 2'h0, 2'h0,
                         reset_cause_pkg::CLASS_WAKE};
            end
            reset_cause_pkg::CAUSE_NONE: begin
                plan.init_class = reset_cause_pkg::CLASS_NONE;
            end
        endcase
    end
endmodule : reset_value_table
